//--- src/pdma_pkg.sv
// Constants for the peripheral DMA channel register block
package pdma_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;
    localparam logic [11:0] OFF_RX_PTR = 12'h100;
    localparam logic [11:0] OFF_RX_CNT = 12'h104;
    localparam logic [11:0] OFF_TX_PTR = 12'h108;
    localparam logic [11:0] OFF_TX_CNT = 12'h10c;
    localparam logic [11:0] OFF_RX_NPTR = 12'h110;
    localparam logic [11:0] OFF_RX_NCNT = 12'h114;
    localparam logic [11:0] OFF_TX_NPTR = 12'h118;
    localparam logic [11:0] OFF_TX_NCNT = 12'h11c;
    localparam logic [11:0] OFF_CONTROL = 12'h120;
    localparam logic [11:0] OFF_STATUS = 12'h124;
    localparam int BIT_RX_EN = 0;
    localparam int BIT_RX_DIS = 1;
    localparam int BIT_TX_EN = 8;
    localparam int BIT_TX_DIS = 9;
    localparam logic [31:0] RST_PTR = 32'h0000_0000;
    localparam logic [15:0] RST_CNT = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [31:0] INC_BYTE = 32'h0000_0001;
    localparam logic [31:0] INC_HALF = 32'h0000_0002;
    localparam logic [31:0] INC_WORD = 32'h0000_0004;
    typedef enum logic [1:0] {ST_IDLE = 2'h1, ST_MOVE = 2'h2} pdma_state_type;
endpackage

//--- src/pdma_channel_regs.sv
// Peripheral DMA channel pair with AXI4-Lite register access
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/100ps
module pdma_channel_regs #(
    parameter bit HALF_DUPLEX = 1'b0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] xfer_size,
    input wire logic rx_ready,
    input wire logic tx_ready,
    output logic rx_mem_req,
    output logic [31:0] rx_mem_addr,
    input wire logic rx_mem_ack,
    output logic tx_mem_req,
    output logic [31:0] tx_mem_addr,
    input wire logic tx_mem_ack,
    output logic rx_segment_done,
    output logic rx_all_buffers_full,
    output logic tx_segment_done,
    output logic tx_all_buffers_empty
);
    // Storage slots: 0 receive, 1 transmit; half-duplex maps both to 0
    logic [31:0] ptr_q [2];
    logic [15:0] cnt_q [2];
    logic [31:0] nptr_q [2];
    logic [15:0] ncnt_q [2];
    logic [1:0] en_q;
    logic [1:0] done_q;
    logic [1:0] all_q;
    pdma_pkg::pdma_state_type state_q [2];
    logic [1:0] slot;
    logic [1:0] chan_ready;
    logic [1:0] mem_ack;
    logic [1:0] step;
    logic [31:0] inc;

    logic aw_have_q;
    logic w_have_q;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic wr_fire;
    logic [31:0] wmask;
    logic [31:0] wr_val;

    // Decoded write targets per slot and per direction
    logic [1:0] wr_ptr;
    logic [1:0] wr_cnt;
    logic [1:0] wr_nptr;
    logic [1:0] wr_ncnt;
    logic [1:0] wr_cnt_dir;
    logic wr_ctrl;
    logic wr_ok;
    logic ctl_rx_en;
    logic ctl_rx_dis;
    logic ctl_tx_en;
    logic ctl_tx_dis;

    assign slot[0] = 1'b0;
    assign slot[1] = HALF_DUPLEX ? 1'b0 : 1'b1;
    assign chan_ready = {tx_ready, rx_ready};
    assign mem_ack = {tx_mem_ack, rx_mem_ack};

    always_comb
    begin
        if (xfer_size == pdma_pkg::SIZE_BYTE)
        begin
            inc = pdma_pkg::INC_BYTE;
        end
        else if (xfer_size == pdma_pkg::SIZE_HALF)
        begin
            inc = pdma_pkg::INC_HALF;
        end
        else
        begin
            inc = pdma_pkg::INC_WORD;
        end
    end

    // Write channel: address and data taken in either order
    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready = !w_have_q && !bvalid_q;
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            awaddr_q <= 12'h000;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end
        else if (wr_fire)
        begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_have_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end
        else if (wr_fire)
        begin
            w_have_q <= 1'b0;
        end
    end

    assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    assign ctl_rx_en = wr_ctrl && wstrb_q[0] && wdata_q[pdma_pkg::BIT_RX_EN];
    assign ctl_rx_dis = wr_ctrl && wstrb_q[0] && wdata_q[pdma_pkg::BIT_RX_DIS];
    assign ctl_tx_en = wr_ctrl && wstrb_q[1] && wdata_q[pdma_pkg::BIT_TX_EN];
    assign ctl_tx_dis = wr_ctrl && wstrb_q[1] && wdata_q[pdma_pkg::BIT_TX_DIS];

    always_comb
    begin
        wr_ptr = 2'h0;
        wr_cnt = 2'h0;
        wr_nptr = 2'h0;
        wr_ncnt = 2'h0;
        wr_cnt_dir = 2'h0;
        wr_ctrl = 1'b0;
        wr_ok = 1'b1;
        if (!wr_fire)
        begin
            wr_ok = 1'b1;
        end
        else if (awaddr_q == pdma_pkg::OFF_RX_PTR)
        begin
            wr_ptr[slot[0]] = 1'b1;
        end
        else if (awaddr_q == pdma_pkg::OFF_RX_CNT)
        begin
            wr_cnt[slot[0]] = 1'b1;
            wr_cnt_dir[0] = 1'b1;
        end
        else if (awaddr_q == pdma_pkg::OFF_TX_PTR)
        begin
            wr_ptr[slot[1]] = 1'b1;
        end
        else if (awaddr_q == pdma_pkg::OFF_TX_CNT)
        begin
            wr_cnt[slot[1]] = 1'b1;
            wr_cnt_dir[1] = 1'b1;
        end
        else if (awaddr_q == pdma_pkg::OFF_RX_NPTR)
        begin
            wr_nptr[slot[0]] = 1'b1;
        end
        else if (awaddr_q == pdma_pkg::OFF_RX_NCNT)
        begin
            wr_ncnt[slot[0]] = 1'b1;
            wr_cnt_dir[0] = 1'b1;
        end
        else if (awaddr_q == pdma_pkg::OFF_TX_NPTR)
        begin
            wr_nptr[slot[1]] = 1'b1;
        end
        else if (awaddr_q == pdma_pkg::OFF_TX_NCNT)
        begin
            wr_ncnt[slot[1]] = 1'b1;
            wr_cnt_dir[1] = 1'b1;
        end
        else if (awaddr_q == pdma_pkg::OFF_CONTROL)
        begin
            wr_ctrl = 1'b1;
        end
        else if (awaddr_q == pdma_pkg::OFF_STATUS)
        begin
            wr_ok = 1'b1;
        end
        else
        begin
            wr_ok = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= pdma_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? pdma_pkg::RESP_OKAY : pdma_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            bvalid_q <= 1'b0;
        end
    end

    // Read channel: one cycle from address to data
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= pdma_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_q <= 1'b1;
            rresp_q <= pdma_pkg::RESP_OKAY;
            rdata_q <= 32'h0000_0000;
            if (s_axi_araddr == pdma_pkg::OFF_RX_PTR)
            begin
                rdata_q <= ptr_q[slot[0]];
            end
            else if (s_axi_araddr == pdma_pkg::OFF_RX_CNT)
            begin
                rdata_q <= {16'h0000, cnt_q[slot[0]]};
            end
            else if (s_axi_araddr == pdma_pkg::OFF_TX_PTR)
            begin
                rdata_q <= ptr_q[slot[1]];
            end
            else if (s_axi_araddr == pdma_pkg::OFF_TX_CNT)
            begin
                rdata_q <= {16'h0000, cnt_q[slot[1]]};
            end
            else if (s_axi_araddr == pdma_pkg::OFF_RX_NPTR)
            begin
                rdata_q <= nptr_q[slot[0]];
            end
            else if (s_axi_araddr == pdma_pkg::OFF_RX_NCNT)
            begin
                rdata_q <= {16'h0000, ncnt_q[slot[0]]};
            end
            else if (s_axi_araddr == pdma_pkg::OFF_TX_NPTR)
            begin
                rdata_q <= nptr_q[slot[1]];
            end
            else if (s_axi_araddr == pdma_pkg::OFF_TX_NCNT)
            begin
                rdata_q <= {16'h0000, ncnt_q[slot[1]]};
            end
            else if (s_axi_araddr == pdma_pkg::OFF_CONTROL)
            begin
                rdata_q <= 32'h0000_0000;
            end
            else if (s_axi_araddr == pdma_pkg::OFF_STATUS)
            begin
                rdata_q[pdma_pkg::BIT_RX_EN] <= en_q[0];
                rdata_q[pdma_pkg::BIT_TX_EN] <= en_q[1];
            end
            else
            begin
                rresp_q <= pdma_pkg::RESP_SLVERR;
            end
        end
        else if (s_axi_rready)
        begin
            rvalid_q <= 1'b0;
        end
    end

    // Request enables
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            en_q <= 2'h0;
        end
        else if (wr_ctrl)
        begin
            if (ctl_rx_dis || (HALF_DUPLEX && ctl_tx_dis))
            begin
                en_q[0] <= 1'b0;
            end
            else if (ctl_rx_en)
            begin
                en_q[0] <= 1'b1;
            end
            if (ctl_tx_dis || (HALF_DUPLEX && (ctl_rx_dis || ctl_rx_en)))
            begin
                en_q[1] <= 1'b0;
            end
            else if (ctl_tx_en && !(HALF_DUPLEX && en_q[0]))
            begin
                en_q[1] <= 1'b1;
            end
        end
    end

    // One engine per direction: request, wait for ack, step
    for (genvar d = 0; d < 2; d++)
    begin : g_eng
        assign step[d] = (state_q[d] == pdma_pkg::ST_MOVE) && mem_ack[d];

        always_ff @(posedge aclk)
        begin
            if (!aresetn)
            begin
                state_q[d] <= pdma_pkg::ST_IDLE;
            end
            else
            begin
                case (state_q[d])
                    pdma_pkg::ST_IDLE:
                    begin
                        if (en_q[d] && chan_ready[d] && cnt_q[slot[d]] != pdma_pkg::RST_CNT)
                        begin
                            state_q[d] <= pdma_pkg::ST_MOVE;
                        end
                    end
                    pdma_pkg::ST_MOVE:
                    begin
                        if (mem_ack[d])
                        begin
                            state_q[d] <= pdma_pkg::ST_IDLE;
                        end
                    end
                    default:
                    begin
                        state_q[d] <= pdma_pkg::ST_IDLE;
                    end
                endcase
            end
        end

        // Set wins over a clearing count write in the same cycle
        always_ff @(posedge aclk)
        begin
            if (!aresetn)
            begin
                done_q[d] <= 1'b0;
                all_q[d] <= 1'b0;
            end
            else if (step[d] && cnt_q[slot[d]] == 16'h0001)
            begin
                done_q[d] <= 1'b1;
                all_q[d] <= all_q[d] || (ncnt_q[slot[d]] == pdma_pkg::RST_CNT);
            end
            else if (wr_cnt_dir[d] && (wdata_q[15:0] & wmask[15:0]) != 16'h0000)
            begin
                done_q[d] <= 1'b0;
                all_q[d] <= 1'b0;
            end
        end

        // Register slot d: software write wins over a data step
        always_ff @(posedge aclk)
        begin
            if (!aresetn)
            begin
                ptr_q[d] <= pdma_pkg::RST_PTR;
                cnt_q[d] <= pdma_pkg::RST_CNT;
                nptr_q[d] <= pdma_pkg::RST_PTR;
                ncnt_q[d] <= pdma_pkg::RST_CNT;
            end
            else
            begin
                if ((step[0] && slot[0] == 1'(d)) || (step[1] && slot[1] == 1'(d)))
                begin
                    if (cnt_q[d] == 16'h0001 && ncnt_q[d] != pdma_pkg::RST_CNT)
                    begin
                        ptr_q[d] <= nptr_q[d];
                        cnt_q[d] <= ncnt_q[d];
                        nptr_q[d] <= pdma_pkg::RST_PTR;
                        ncnt_q[d] <= pdma_pkg::RST_CNT;
                    end
                    else
                    begin
                        ptr_q[d] <= ptr_q[d] + inc;
                        cnt_q[d] <= cnt_q[d] - 16'h0001;
                    end
                end
                if (wr_ptr[d])
                begin
                    ptr_q[d] <= (ptr_q[d] & ~wmask) | (wdata_q & wmask);
                end
                if (wr_cnt[d])
                begin
                    cnt_q[d] <= (cnt_q[d] & ~wmask[15:0]) | (wdata_q[15:0] & wmask[15:0]);
                end
                if (wr_nptr[d])
                begin
                    nptr_q[d] <= (nptr_q[d] & ~wmask) | (wdata_q & wmask);
                end
                if (wr_ncnt[d])
                begin
                    ncnt_q[d] <= (ncnt_q[d] & ~wmask[15:0]) | (wdata_q[15:0] & wmask[15:0]);
                end
            end
        end
    end

    assign rx_mem_req = state_q[0] == pdma_pkg::ST_MOVE;
    assign tx_mem_req = state_q[1] == pdma_pkg::ST_MOVE;
    assign rx_mem_addr = ptr_q[slot[0]];
    assign tx_mem_addr = ptr_q[slot[1]];
    assign rx_segment_done = done_q[0];
    assign rx_all_buffers_full = all_q[0];
    assign tx_segment_done = done_q[1];
    assign tx_all_buffers_empty = all_q[1];
endmodule

//--- bench/pdma_props.sv
// Concurrent checks on the DMA channel register block ports
`timescale 1ns/100ps
module pdma_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rx_mem_req,
    input wire logic rx_mem_ack,
    input wire logic tx_mem_req,
    input wire logic tx_mem_ack,
    input wire logic rx_segment_done,
    input wire logic rx_all_buffers_full,
    input wire logic tx_segment_done,
    input wire logic tx_all_buffers_empty
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write answer late");
    chk_wr_closed: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channel open during answer");
    chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    chk_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 12'h124
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
    chk_rx_hold: assert property (rx_mem_req && !rx_mem_ack |=> rx_mem_req)
        else $error("rx item dropped");
    chk_rx_gap: assert property (rx_mem_req && rx_mem_ack |=> !rx_mem_req)
        else $error("rx request held after ack");
    chk_tx_gap: assert property (tx_mem_req && tx_mem_ack |=> !tx_mem_req)
        else $error("tx request held after ack");
    chk_rx_done: assert property ($rose(rx_segment_done) |-> $past(rx_mem_ack) && $past(rx_mem_req))
        else $error("rx done without item");
    chk_tx_done: assert property ($rose(tx_segment_done) |-> $past(tx_mem_ack) && $past(tx_mem_req))
        else $error("tx done without item");
    chk_all_done: assert property (!(rx_all_buffers_full && !rx_segment_done) && !(tx_all_buffers_empty && !tx_segment_done))
        else $error("buffer flag without done");
    cover property (rx_all_buffers_full);
    cover property (tx_all_buffers_empty);
    cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
bind pdma_channel_regs pdma_props u_props (.*);

//--- bench/pdma_periph_model.sv
// Peripheral and memory model: always ready, one-cycle ack per item
`timescale 1ns/100ps
module pdma_periph_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic slow,
    input wire logic rx_mem_req,
    input wire logic tx_mem_req,
    output logic rx_ready,
    output logic tx_ready,
    output logic rx_mem_ack,
    output logic tx_mem_ack
);
    logic [1:0] rx_wait_q;
    logic [1:0] tx_wait_q;
    assign rx_ready = 1'b1;
    assign tx_ready = 1'b1;
    // Slow mode stalls each item by a few cycles
    always_ff @(posedge aclk)
    begin
        rx_mem_ack <= 1'b0;
        tx_mem_ack <= 1'b0;
        if (!aresetn)
        begin
            rx_wait_q <= 2'h0;
            tx_wait_q <= 2'h0;
        end
        else
        begin
            if (rx_mem_req && !rx_mem_ack)
            begin
                rx_wait_q <= (!slow || rx_wait_q == 2'h3) ? 2'h0 : rx_wait_q + 2'h1;
                rx_mem_ack <= !slow || rx_wait_q == 2'h3;
            end
            if (tx_mem_req && !tx_mem_ack)
            begin
                tx_wait_q <= (!slow || tx_wait_q == 2'h3) ? 2'h0 : tx_wait_q + 2'h1;
                tx_mem_ack <= !slow || tx_wait_q == 2'h3;
            end
        end
    end
endmodule

//--- bench/tb.sv
// Self-checking bench for the DMA channel register block
`timescale 1ns/100ps
module tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic [11:0] s_axi_araddr = 12'h0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic [1:0] xfer_size = 2'h0;
    logic slow = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, rx_mem_addr, tx_mem_addr, d;
    logic rx_ready, tx_ready, rx_mem_req, tx_mem_req, rx_mem_ack, tx_mem_ack;
    logic rx_segment_done, rx_all_buffers_full, tx_segment_done, tx_all_buffers_empty;
    logic [31:0] hd_rdata, hd_seen, rx_last, tx_last;
    logic hd_on = 1'b0;
    logic [11:0] hd_ctl [6] = '{12'h100, 12'h001, 12'h100, 12'h200, 12'h100, 12'h002};
    logic [11:0] fd_sts [6] = '{12'h100, 12'h101, 12'h101, 12'h001, 12'h101, 12'h100};
    logic [11:0] hd_sts [6] = '{12'h100, 12'h001, 12'h001, 12'h000, 12'h100, 12'h000};
    logic [11:0] ctl_tbl [10] = '{12'h001, 12'h000, 12'h003, 12'h100, 12'h000, 12'h200, 12'h101, 12'h300, 12'h002, 12'h101};
    logic [11:0] sts_tbl [10] = '{12'h001, 12'h001, 12'h000, 12'h100, 12'h100, 12'h000, 12'h101, 12'h001, 12'h000, 12'h101};
    int mismatches = 0;
    int n_tests = 0;
    int rx_items = 0;
    int tx_items = 0;
    int k;
    pdma_channel_regs uut (.*, .s_axi_awprot(3'h0), .s_axi_wstrb(4'hf), .s_axi_arprot(3'h0));
    // Half-duplex twin: sees the bus only while hd_on, never moves data
    pdma_channel_regs #(.HALF_DUPLEX(1'b1)) uut_hd (.*, .s_axi_awprot(3'h0), .s_axi_wstrb(4'hf), .s_axi_arprot(3'h0),
        .s_axi_awvalid(s_axi_awvalid && hd_on), .s_axi_wvalid(s_axi_wvalid && hd_on),
        .s_axi_arvalid(s_axi_arvalid && hd_on), .s_axi_awready(), .s_axi_wready(), .s_axi_bresp(),
        .s_axi_bvalid(), .s_axi_arready(), .s_axi_rdata(hd_rdata), .s_axi_rresp(), .s_axi_rvalid(),
        .rx_ready(1'b0), .tx_ready(1'b0), .rx_mem_req(), .rx_mem_addr(), .rx_mem_ack(1'b0), .tx_mem_req(),
        .tx_mem_addr(), .tx_mem_ack(1'b0), .rx_segment_done(), .rx_all_buffers_full(), .tx_segment_done(),
        .tx_all_buffers_empty());
    pdma_periph_model peer (.*);
    always #2 aclk = ~aclk;
    always @(posedge aclk)
    begin
        if (rx_mem_req && rx_mem_ack)
            rx_items <= rx_items + 1;
        if (tx_mem_req && tx_mem_ack)
            tx_items <= tx_items + 1;
        if (rx_mem_req && rx_mem_ack)
            rx_last <= rx_mem_addr;
        if (tx_mem_req && tx_mem_ack)
            tx_last <= tx_mem_addr;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
        logic ta, tw, bv;
        logic [1:0] r;
        bv = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!bv)
        begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            bv = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ta)
                s_axi_awvalid <= 1'b0;
            if (tw)
                s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        check("bresp", {30'h0, r}, {30'h0, er});
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic ta, rv;
        logic [1:0] r;
        logic [31:0] v;
        rv = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!rv)
        begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            rv = s_axi_rvalid;
            r = s_axi_rresp;
            v = s_axi_rdata;
            hd_seen = hd_rdata;
            @(posedge aclk);
            if (ta)
                s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        check("rdata", v, exp);
        check("rresp", {30'h0, r}, {30'h0, er});
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        conclude;
    end
    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        for (k = 0; k < 10; k++)
            rd(12'h100 + 12'(4 * k), 32'h0, 2'h0);
        rd(12'h200, 32'h0, 2'h2);
        wr(12'h0fc, 32'h1, 2'h2);
        $display("reset and map test done");
        for (k = 0; k < 10; k++)
        begin
            wr(pdma_pkg::OFF_CONTROL, {20'h0, ctl_tbl[k]}, 2'h0);
            rd(pdma_pkg::OFF_STATUS, {20'h0, sts_tbl[k]}, 2'h0);
        end
        wr(pdma_pkg::OFF_STATUS, 32'h0, 2'h0);
        rd(pdma_pkg::OFF_STATUS, 32'h101, 2'h0);
        check("idle items", 32'(rx_items + tx_items), 32'h0);
        wr(pdma_pkg::OFF_CONTROL, 32'h202, 2'h0);
        $display("control test done");
        hd_on <= 1'b1;
        wr(pdma_pkg::OFF_TX_PTR, 32'h4444_0000, 2'h0);
        rd(pdma_pkg::OFF_RX_PTR, 32'h0, 2'h0);
        check("hd rx ptr", hd_seen, 32'h4444_0000);
        wr(pdma_pkg::OFF_RX_NCNT, 32'h7, 2'h0);
        rd(pdma_pkg::OFF_TX_NCNT, 32'h0, 2'h0);
        check("hd tx ncnt", hd_seen, 32'h7);
        for (k = 0; k < 6; k++)
        begin
            wr(pdma_pkg::OFF_CONTROL, {20'h0, hd_ctl[k]}, 2'h0);
            rd(pdma_pkg::OFF_STATUS, {20'h0, fd_sts[k]}, 2'h0);
            check("hd status", hd_seen, {20'h0, hd_sts[k]});
        end
        hd_on <= 1'b0;
        wr(pdma_pkg::OFF_CONTROL, 32'h202, 2'h0);
        $display("half-duplex test done");
        for (k = 0; k < 8; k++)
        begin
            d = 32'h5a5a_a501 + 32'(k);
            wr(12'h100 + 12'(4 * k), d, 2'h0);
            rd(12'h100 + 12'(4 * k), k[0] ? {16'h0, d[15:0]} : d, 2'h0);
        end
        $display("register test done");
        wr(pdma_pkg::OFF_RX_PTR, 32'h1000, 2'h0);
        wr(pdma_pkg::OFF_RX_CNT, 32'h2, 2'h0);
        wr(pdma_pkg::OFF_RX_NPTR, 32'h2000, 2'h0);
        wr(pdma_pkg::OFF_RX_NCNT, 32'h1, 2'h0);
        wr(pdma_pkg::OFF_CONTROL, 32'h1, 2'h0);
        for (k = 0; k < 300 && rx_all_buffers_full !== 1'b1; k++)
            @(posedge aclk);
        repeat (8) @(posedge aclk);
        check("rx done", {31'h0, rx_segment_done}, 32'h1);
        check("rx full", {31'h0, rx_all_buffers_full}, 32'h1);
        check("rx items", 32'(rx_items), 32'h3);
        check("rx addr", rx_last, 32'h2000);
        rd(pdma_pkg::OFF_RX_PTR, 32'h2001, 2'h0);
        rd(pdma_pkg::OFF_RX_CNT, 32'h0, 2'h0);
        rd(pdma_pkg::OFF_RX_NPTR, 32'h0, 2'h0);
        rd(pdma_pkg::OFF_RX_NCNT, 32'h0, 2'h0);
        $display("rx chain test done");
        xfer_size <= 2'h1;
        slow <= 1'b1;
        wr(pdma_pkg::OFF_TX_PTR, 32'h3000, 2'h0);
        wr(pdma_pkg::OFF_TX_CNT, 32'h3, 2'h0);
        wr(pdma_pkg::OFF_TX_NCNT, 32'h0, 2'h0);
        wr(pdma_pkg::OFF_CONTROL, 32'h100, 2'h0);
        for (k = 0; k < 300 && tx_all_buffers_empty !== 1'b1; k++)
            @(posedge aclk);
        repeat (8) @(posedge aclk);
        check("tx items", 32'(tx_items), 32'h3);
        check("tx done", {31'h0, tx_segment_done}, 32'h1);
        check("tx empty", {31'h0, tx_all_buffers_empty}, 32'h1);
        check("tx addr", tx_last, 32'h3004);
        rd(pdma_pkg::OFF_TX_PTR, 32'h3006, 2'h0);
        xfer_size <= 2'h2;
        wr(pdma_pkg::OFF_TX_CNT, 32'h2, 2'h0);
        check("tx empty", {31'h0, tx_all_buffers_empty}, 32'h0);
        for (k = 0; k < 300 && tx_all_buffers_empty !== 1'b1; k++)
            @(posedge aclk);
        repeat (8) @(posedge aclk);
        check("tx items", 32'(tx_items), 32'h5);
        check("tx addr", tx_last, 32'h300a);
        rd(pdma_pkg::OFF_TX_PTR, 32'h300e, 2'h0);
        $display("tx step test done");
        conclude;
    end
endmodule
